// >>> verilog/nipc_regs.vh
// Register offsets, field positions, encodings and reset values of the interrupt controller.
`ifndef NIPC_REGS_VH
`define NIPC_REGS_VH
// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define NIPC_IDX_PRIO0 8'h1C
`define NIPC_IDX_PRIO1 8'h1D
`define NIPC_IDX_PRIO2 8'h1E
`define NIPC_IDX_PRIO3 8'h1F
`define NIPC_IDX_CCR 8'h20
`define NIPC_IDX_PEND 8'h21
`define NIPC_IDX_STAT 8'h22
`define NIPC_ADDR_W 10
`define NIPC_ADDR_LSB 2
// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define NIPC_PRIO_RESET 8'hFF
`define NIPC_CCR_RESET 8'h28
// -----------------------------------------------------------------
// Condition code fields
// -----------------------------------------------------------------
`define NIPC_CC_UPPER 5
`define NIPC_CC_LOWER 3
// -----------------------------------------------------------------
// Mask level codes {upper, lower}
// -----------------------------------------------------------------
`define NIPC_LVL0 2'h2
`define NIPC_LVL1 2'h1
`define NIPC_LVL2 2'h0
`define NIPC_LVL3 2'h3
// -----------------------------------------------------------------
// Vectors
// -----------------------------------------------------------------
`define NIPC_VEC_BASE 16'hFFE0
`define NIPC_VEC_TRAP 16'hFFFC
`define NIPC_VEC_RESET 16'hFFFE
`define NIPC_NUM_VEC 16
`define NIPC_NUM_SRC 14
`define NIPC_SRC_W 4
`endif

// >>> verilog/nipc_lvl_decode.v
// Converts a two-bit mask level code into a numeric rank.
`timescale 1ns/1ps
`include "nipc_regs.vh"
module nipc_lvl_decode (
  // Code in
  input wire [1:0] code_i,
  // Rank out, 0 lowest
  output reg [1:0] rank_o
);
  always @* begin
    case (code_i)
      `NIPC_LVL0: rank_o = 2'h0;
      `NIPC_LVL1: rank_o = 2'h1;
      `NIPC_LVL2: rank_o = 2'h2;
      default: rank_o = 2'h3;
    endcase
  end
endmodule

// >>> verilog/nipc_sync.v
// Three-stage synchroniser for a bank of asynchronous request lines.
`timescale 1ns/1ps
module nipc_sync #(
  parameter W = 14
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Raw lines
  input wire [W-1:0] d_i,
  // Agreed lines
  output reg [W-1:0] q_o
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  // A line changes only once stages two and three agree, filtering single-cycle glitches.
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end
endmodule

// >>> verilog/nipc_top.v
// Nested interrupt priority controller with Wishbone register access and core handshake.
`timescale 1ns/1ps
`include "nipc_regs.vh"
module nipc_top #(
  parameter NSRC = `NIPC_NUM_SRC
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [`NIPC_ADDR_W-1:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Asynchronous interrupt request lines, index 0 highest hardware priority
  input wire [NSRC-1:0] irq_i,
  // Core handshake
  input wire insn_done_i,
  input wire trap_i,
  input wire ret_i,
  input wire [15:0] pc_i,
  input wire [7:0] x_i,
  input wire [7:0] a_i,
  output wire [7:0] condition_code_register_o,
  // Context push and pop toward the core
  output reg push_o,
  output reg [39:0] push_data_o,
  output reg pop_o,
  input wire [39:0] pop_data_i,
  output reg [39:0] restore_o,
  output reg restore_valid_o,
  // Vector jump
  output reg jump_o,
  output reg [15:0] vector_o,
  output reg [3:0] ack_src_o
);
  // -----------------------------------------------------------------
  // State encoding
  // -----------------------------------------------------------------
  localparam ST_IDLE = 4'h1;
  localparam ST_WAIT = 4'h2;
  localparam ST_PUSH = 4'h4;
  localparam ST_JUMP = 4'h8;

  reg [3:0] state;
  reg [7:0] prio [0:3];
  reg [7:0] ccr;
  reg [3:0] sel_src;
  reg sel_trap;
  reg [1:0] sel_code;
  reg started;
  wire [NSRC-1:0] req;
  wire [1:0] cur_rank;
  wire [`NIPC_NUM_VEC*2-1:0] code_bus;
  wire [`NIPC_NUM_VEC*2-1:0] rank_bus;
  reg found;
  reg [3:0] win_src;
  reg [1:0] win_rank;
  reg [1:0] win_code;
  integer i;
  integer k;
  wire wb_req = cyc_i && stb_i && !ack_o;
  wire wb_wr = wb_req && we_i;
  wire [7:0] wb_idx = adr_i[`NIPC_ADDR_W-1:`NIPC_ADDR_LSB];

  assign condition_code_register_o = ccr;

  // -----------------------------------------------------------------
  // Request synchronisation and level decode
  // -----------------------------------------------------------------
  nipc_sync #(.W(NSRC)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(irq_i),
    .q_o(req)
  );

  nipc_lvl_decode u_cur (
    .code_i({ccr[`NIPC_CC_UPPER], ccr[`NIPC_CC_LOWER]}),
    .rank_o(cur_rank)
  );

  genvar g;
  generate
    for (g = 0; g < `NIPC_NUM_VEC; g = g + 1) begin : g_lvl
      // Two-bit field per vector, four fields per register.
      assign code_bus[g*2 +: 2] = prio[g/4][(g%4)*2 +: 2];
      nipc_lvl_decode u_dec (
        .code_i(code_bus[g*2 +: 2]),
        .rank_o(rank_bus[g*2 +: 2])
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // Arbitration
  // -----------------------------------------------------------------
  // Strict greater-than keeps level 3 routines from ever being preempted by a request line.
  always @* begin
    found = 1'b0;
    win_src = 4'h0;
    win_rank = 2'h0;
    win_code = 2'h0;
    for (i = 0; i < NSRC; i = i + 1) begin
      if (req[i] && rank_bus[i*2 +: 2] > cur_rank &&
          (!found || rank_bus[i*2 +: 2] > win_rank)) begin
        found = 1'b1;
        win_src = i[3:0];
        win_rank = rank_bus[i*2 +: 2];
        win_code = code_bus[i*2 +: 2];
      end
    end
  end

  // -----------------------------------------------------------------
  // Entry and return sequencer
  // -----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      ccr <= `NIPC_CCR_RESET;
      sel_src <= 4'h0;
      sel_trap <= 1'b0;
      sel_code <= 2'h0;
      started <= 1'b0;
      push_o <= 1'b0;
      push_data_o <= 40'h0000000000;
      pop_o <= 1'b0;
      restore_o <= 40'h0000000000;
      restore_valid_o <= 1'b0;
      jump_o <= 1'b0;
      vector_o <= 16'h0000;
      ack_src_o <= 4'h0;
    end else begin
      push_o <= 1'b0;
      pop_o <= 1'b0;
      restore_valid_o <= 1'b0;
      jump_o <= 1'b0;
      // The bus may write the condition codes from the first cycle after reset.
      if (wb_wr && wb_idx == `NIPC_IDX_CCR && sel_i[0]) begin
        ccr <= dat_i[7:0];
      end
      if (!started) begin
        // Reset vector is fetched first, never masked.
        started <= 1'b1;
        jump_o <= 1'b1;
        vector_o <= `NIPC_VEC_RESET;
      end else begin
        if (pop_o) begin
          restore_o <= pop_data_i;
          restore_valid_o <= 1'b1;
          ccr <= pop_data_i[7:0];
        end
        case (state)
          ST_IDLE: begin
            if (ret_i) begin
              pop_o <= 1'b1;
            end else if (trap_i) begin
              sel_trap <= 1'b1;
              sel_code <= `NIPC_LVL3;
              state <= ST_WAIT;
            end else if (found) begin
              sel_trap <= 1'b0;
              sel_src <= win_src;
              sel_code <= win_code;
              state <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (insn_done_i) begin
              state <= ST_PUSH;
            end
          end
          ST_PUSH: begin
            push_o <= 1'b1;
            push_data_o <= {pc_i, x_i, a_i, ccr};
            ccr[`NIPC_CC_UPPER] <= sel_code[1];
            ccr[`NIPC_CC_LOWER] <= sel_code[0];
            state <= ST_JUMP;
          end
          ST_JUMP: begin
            jump_o <= 1'b1;
            ack_src_o <= sel_src;
            // Lower source index gets a higher address: higher hardware priority.
            vector_o <= sel_trap ? `NIPC_VEC_TRAP :
              (`NIPC_VEC_TRAP - {11'h000, sel_src + 4'h1, 1'b0});
            state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Wishbone slave
  // -----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      for (k = 0; k < 4; k = k + 1) begin
        prio[k] <= `NIPC_PRIO_RESET;
      end
    end else begin
      ack_o <= wb_req;
      if (wb_req) begin
        dat_o <= 32'h00000000;
        case (wb_idx)
          `NIPC_IDX_PRIO0, `NIPC_IDX_PRIO1, `NIPC_IDX_PRIO2, `NIPC_IDX_PRIO3: begin
            dat_o[7:0] <= prio[wb_idx[1:0]];
            if (we_i && sel_i[0]) begin
              prio[wb_idx[1:0]] <= dat_i[7:0];
            end
          end
          `NIPC_IDX_CCR: dat_o[7:0] <= ccr;
          `NIPC_IDX_PEND: dat_o[NSRC-1:0] <= req;
          `NIPC_IDX_STAT: dat_o[7:0] <= {state, sel_src};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// >>> test/nipc_top_props.sv
// Concurrent checks on the ports of the interrupt controller.
`timescale 1ns/1ps
module nipc_top_props #(
  parameter NSRC = 14
) (
  // Clock, reset and bus
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  // Core side
  input wire insn_done_i,
  input wire ret_i,
  input wire [15:0] pc_i,
  input wire [7:0] x_i,
  input wire [7:0] a_i,
  input wire [39:0] pop_data_i,
  input wire [39:0] restore_o,
  input wire [7:0] condition_code_register_o,
  input wire push_o,
  input wire [39:0] push_data_o,
  input wire pop_o,
  input wire restore_valid_o,
  input wire jump_o,
  input wire [15:0] vector_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_enter;
    push_o ##1 jump_o;
  endsequence
  sequence s_leave;
    pop_o ##1 restore_valid_o;
  endsequence
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held");
  AST_ENTRY: assert property (push_o |-> s_enter) else $error("no jump after push");
  AST_AFTER_INSN: assert property (push_o |-> $past(insn_done_i, 2)) else $error("early push");
  AST_PUSH_CC: assert property (push_o |->
    push_data_o == $past({pc_i, x_i, a_i, condition_code_register_o}))
    else $error("saved context wrong");
  AST_POP_RET: assert property (pop_o |-> $past(ret_i) ##0 s_leave) else $error("bad pop");
  AST_RESTORE: assert property (pop_o |=>
    condition_code_register_o == $past(pop_data_i[7:0]) && restore_o == $past(pop_data_i))
    else $error("cc not restored");
  AST_VEC_TOP: assert property (jump_o |-> vector_o >= 16'hFFE0 && !vector_o[0])
    else $error("vector outside table");
  AST_RESET_VEC: assert property ($fell(rst_i) |->
    ##[0:2] (jump_o && vector_o == 16'hFFFE))
    else $error("no reset vector");
  AST_CC_CAUSE: assert property ($changed(condition_code_register_o) |->
    push_o || restore_valid_o || ack_o) else $error("cc changed alone");
endmodule
bind nipc_top nipc_top_props #(.NSRC(NSRC)) u_props (.*);

// >>> test/nipc_core_model.sv
// Behavioural core: finishes instructions, keeps the stack and executes returns.
`timescale 1ns/1ps
module nipc_core_model (
  input wire clk_i,
  input wire rst_i,
  input wire push_o,
  input wire [39:0] push_data_o,
  input wire pop_o,
  input wire ret_req_i,
  output reg insn_done_i = 0,
  output reg ret_i = 0,
  output reg [15:0] pc_i = 0,
  output reg [7:0] x_i = 0,
  output reg [7:0] a_i = 0,
  output wire [39:0] pop_data_i
);
  reg [39:0] stk [0:7];
  integer sp = 0;
  // An empty stack shows a changing pattern, so a stray pop never reads stale data.
  assign pop_data_i = (sp > 0) ? stk[sp-1] : {5{pc_i[7:0]}};
  always @(posedge clk_i) begin
    insn_done_i <= ($urandom % 3) == 0;
    pc_i <= $urandom;
    x_i <= $urandom;
    a_i <= $urandom;
    ret_i <= ret_req_i;
    if (rst_i) begin
      sp <= 0;
    end else if (push_o) begin
      stk[sp] <= push_data_o;
      sp <= sp + 1;
    end else if (pop_o && sp > 0) begin
      sp <= sp - 1;
    end
  end
endmodule

// >>> test/nipc_top_tb.sv
// Self-checking bench for the nested interrupt priority controller.
`timescale 1ns/1ps
module nipc_top_tb;
  reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, trap_i = 0, ret_req_i = 0;
  reg [9:0] adr_i = 0;
  reg [3:0] sel_i = 4'hF;
  reg [31:0] dat_i = 0;
  reg [13:0] irq_i = 0;
  reg [7:0] rd, pr [0:3];
  wire [31:0] dat_o;
  wire ack_o, insn_done_i, ret_i, push_o, pop_o, restore_valid_o, jump_o;
  wire [15:0] pc_i, vector_o;
  wire [7:0] x_i, a_i, condition_code_register_o;
  wire [39:0] push_data_o, pop_data_i, restore_o;
  wire [3:0] ack_src_o;
  integer n_mismatch = 0, check_count = 0, ticks = 0, i, s, l;
  always #5 clk_i = ~clk_i;
  nipc_top u_dut (.*);
  nipc_core_model u_core (.*);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [1:0] code(input integer lv);
    code = (lv == 0) ? 2'h2 : (lv == 1) ? 2'h1 : (lv == 2) ? 2'h0 : 2'h3;
  endfunction
  task chk(input string nm, input [39:0] seen, input [39:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wb(input w, input [7:0] idx, input [7:0] d, output [7:0] q);
    begin
      @(posedge clk_i);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= {idx, 2'h0};
      dat_i <= ($urandom << 8) | d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      q = dat_o[7:0];
      cyc_i <= 0;
      stb_i <= 0;
    end
  endtask
  task setlvl(input integer src, input integer lv);
    begin
      pr[src/4][(src%4)*2 +: 2] = code(lv);
      wb(1, 8'h1C + src / 4, pr[src/4], rd);
    end
  endtask
  task setcc(input integer lv);
    reg [1:0] c;
    begin
      c = code(lv);
      wb(1, 8'h20, {2'h0, c[1], 1'b0, c[0], 3'h0}, rd);
    end
  endtask
  // Waits for the vector jump; the mask was loaded one edge earlier by the push.
  task take(input [15:0] v, input [1:0] c);
    begin
      // Step past the edge at which a previous jump pulse may still be seen.
      @(posedge clk_i);
      while (jump_o !== 1'b1) @(posedge clk_i);
      chk("vector", vector_o, v);
      chk("mask", {condition_code_register_o[5], condition_code_register_o[3]}, c);
    end
  endtask
  // The request line is already low; let the synchroniser drain before returning.
  task ret(input [1:0] c);
    begin
      repeat (5) @(posedge clk_i);
      ret_req_i <= 1;
      @(posedge clk_i);
      ret_req_i <= 0;
      while (restore_valid_o !== 1'b1) @(posedge clk_i);
      chk("restore", {condition_code_register_o[5], condition_code_register_o[3]}, c);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    ticks = ticks + 1;
    if (ticks == 5000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test;
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rd = $urandom(64835);
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    for (i = 0; i < 4; i = i + 1) begin
      wb(0, 8'h1C + i, 8'h00, rd);
      chk("prio reset", rd, 8'hFF);
      pr[i] = $urandom;
      wb(1, 8'h1C + i, pr[i], rd);
      wb(0, 8'h1C + i, 8'h00, rd);
      chk("prio rw", rd, pr[i]);
    end
    wb(0, 8'h20, 8'h00, rd);
    chk("cc reset", rd, 8'h28);
    wb(1, 8'h40, 8'h5A, rd);
    wb(0, 8'h40, 8'h00, rd);
    chk("unmapped", rd, 8'h00);
    for (l = 1; l < 4; l = l + 1) begin
      s = $urandom % 14;
      setlvl(s, l);
      setcc(0);
      irq_i <= 14'h1 << s;
      take(16'hFFFC - 2 * (s + 1), code(l));
      chk("source", ack_src_o, s);
      irq_i <= 0;
      ret(code(0));
    end
    setlvl(2, 1);
    setlvl(5, 1);
    setlvl(9, 2);
    setcc(0);
    irq_i <= 14'h0024;
    take(16'hFFF6, code(1));
    irq_i <= 14'h0200;
    take(16'hFFE8, code(2));
    irq_i <= 0;
    ret(code(1));
    ret(code(0));
    setcc(3);
    trap_i <= 1;
    @(posedge clk_i);
    trap_i <= 0;
    take(16'hFFFC, code(3));
    ret(code(3));
    end_of_test;
  end
endmodule
